/* File: rar_host_model.sv */
// host side of the routing pair: write strobes and reads
// assumes reads are combinational and writes land on the strobe edge
`default_nettype none
module rar_host_model (
  input wire logic core_clk,
  input wire logic [rar_pkg::DATA_W-1:0] reg_rdata,
  output logic [rar_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic [rar_pkg::DATA_W-1:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import rar_pkg::*;
  initial reg_addr = 7'h00;
  initial reg_wr = 1'b0;
  initial reg_wdata = 8'h00;
  // input mode is not kept equal here; the bench writes opposite bit 7 values to the two registers
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= (a == 7'h17) ? {d[7:2], 2'h0} : d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : rar_host_model
`default_nettype wire

/* File: rar_line_route.sv */
// one right line input: level code to mixer connect and attenuation
// assumes a level code from the register bank in the same clock domain
`default_nettype none
module rar_line_route (
  input wire logic [3:0] level_code,
  output logic connect,
  output logic [3:0] atten_steps
);
  import rar_pkg::*;
  // codes 0..8 connect; 15 and the reserved codes leave the input open
  assign connect = (level_code <= LEVEL_MAX_CODE);
  assign atten_steps = connect ? level_code : 4'h0;
endmodule : rar_line_route
`default_nettype wire

/* File: rar_pkg.sv */
// package for the right record input routing register pair
// assumes a simple internal register port: address, write strobe, write data, read data
`default_nettype none
package rar_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [6:0] LINE_ONE_ROUTE_OFFS = 7'h16;
  localparam logic [6:0] LINE_TWO_ROUTE_OFFS = 7'h17;
  localparam int DIFF_BIT = 7;
  localparam int LEVEL_MSB = 6;
  localparam int LEVEL_LSB = 3;
  localparam int POWER_BIT = 2;
  localparam int BIAS_BIT = 2;
  localparam int STEP_MSB = 1;
  localparam int STEP_LSB = 0;
  localparam logic [3:0] LEVEL_MAX_CODE = 4'h8;
  localparam logic [3:0] LEVEL_OPEN_CODE = 4'hF;
  localparam logic [7:0] LINE_ONE_RESET = 8'h78;
  localparam logic [7:0] LINE_TWO_RESET = 8'h78;
  localparam logic [1:0] STEP_ONE_FS = 2'h0;
  localparam logic [1:0] STEP_TWO_FS = 2'h1;
  typedef enum logic [1:0] {
    RAR_STEP_EVERY = 2'b00,
    RAR_STEP_EVERY_TWO = 2'b01,
    RAR_STEP_OFF = 2'b10
  } rar_step_e;
endpackage : rar_pkg
`default_nettype wire

/* File: rar_route_regs.sv */
// right record input routing register pair and its decoded controls
// assumes a host register port on core_clk; writes take effect on the strobe edge
`default_nettype none
// Function
// R1 - first register bit 7 selects input-one differential
// R2 - second register bit 7 selects input-two differential
// R3 - host keeps shared input mode consistent; the bench writes opposite bit 7 values to the two registers
// R4 - level field bits 6:3, 1.5 dB steps
// R5 - valid level code connects input to mixer
// R6 - code 1111 disconnects; reset value 1111
// R7 - host never writes codes 1001 to 1110
// R8 - first register bit 2 powers converter
// R9 - bits 1:0 choose soft-stepping rate
// R10 - second register bit 2 enables weak bias
// R11 - second register bits 1:0 read zero
// R12 - writes update at once, reads return them
module rar_route_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [rar_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [rar_pkg::DATA_W-1:0] reg_wdata,
  output logic [rar_pkg::DATA_W-1:0] reg_rdata,
  output logic right_line_input_one_diff,
  output logic right_line_input_two_diff,
  output logic right_line_input_one_connect,
  output logic right_line_input_two_connect,
  output logic [3:0] right_line_input_one_atten,
  output logic [3:0] right_line_input_two_atten,
  output logic right_adc_power_up,
  output logic unselected_bias_en,
  output logic input_gain_stage_step_en,
  output logic input_gain_stage_step_two_fs
);
  import rar_pkg::*;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] line_one_reg;
  logic [5:0] line_two_reg;
  wire sel_one = (reg_addr == LINE_ONE_ROUTE_OFFS);
  wire sel_two = (reg_addr == LINE_TWO_ROUTE_OFFS);
  wire wr_one = reg_wr && sel_one;
  wire wr_two = reg_wr && sel_two;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_one_reg <= LINE_ONE_RESET; // R6 R8
    end else if (wr_one) begin
      line_one_reg <= reg_wdata; // R12
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_two_reg <= LINE_TWO_RESET[7:2]; // R6
    end else if (wr_two) begin
      line_two_reg <= reg_wdata[7:2]; // R11 R12
    end
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  wire [7:0] line_two_view = {line_two_reg, 2'b00}; // R11
  assign reg_rdata = sel_one ? line_one_reg : (sel_two ? line_two_view : 8'h00); // R12

  // ----------------------------------------
  // decoded controls
  // ----------------------------------------
  assign right_line_input_one_diff = line_one_reg[DIFF_BIT]; // R1
  assign right_line_input_two_diff = line_two_reg[DIFF_BIT-2]; // R2
  assign right_adc_power_up = line_one_reg[POWER_BIT]; // R8
  assign unselected_bias_en = line_two_reg[BIAS_BIT-2]; // R10
  wire [1:0] step_code = line_one_reg[STEP_MSB:STEP_LSB];
  assign input_gain_stage_step_en = (step_code == STEP_ONE_FS) || (step_code == STEP_TWO_FS); // R9
  assign input_gain_stage_step_two_fs = (step_code == STEP_TWO_FS); // R9

  rar_line_route u_line_one (
    .level_code(line_one_reg[LEVEL_MSB:LEVEL_LSB]), // R4
    .connect(right_line_input_one_connect), // R5 R6
    .atten_steps(right_line_input_one_atten)
  );

  rar_line_route u_line_two (
    .level_code(line_two_reg[LEVEL_MSB-2:LEVEL_LSB-2]), // R4
    .connect(right_line_input_two_connect), // R5 R6
    .atten_steps(right_line_input_two_atten)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_one_write;
    @(posedge core_clk) disable iff (rst) wr_one |=> (line_one_reg == $past(reg_wdata));
  endproperty
  a_one_write: assert property (p_one_write) else $error("line one write lost"); // R12

  property p_two_write;
    @(posedge core_clk) disable iff (rst) wr_two |=> (line_two_view == {$past(reg_wdata[7:2]), 2'b00});
  endproperty
  a_two_write: assert property (p_two_write) else $error("line two write lost"); // R12

  property p_two_low_zero;
    @(posedge core_clk) disable iff (rst) sel_two |-> (reg_rdata[1:0] == 2'b00);
  endproperty
  a_two_low_zero: assert property (p_two_low_zero) else $error("reserved bits not zero"); // R11

  property p_connect_one;
    @(posedge core_clk) disable iff (rst)
      wr_one && (reg_wdata[6:3] <= LEVEL_MAX_CODE) |=> right_line_input_one_connect;
  endproperty
  a_connect_one: assert property (p_connect_one) else $error("input one not connected"); // R5

  property p_open_two;
    @(posedge core_clk) disable iff (rst)
      wr_two && (reg_wdata[6:3] == LEVEL_OPEN_CODE) |=> !right_line_input_two_connect;
  endproperty
  a_open_two: assert property (p_open_two) else $error("input two not disconnected"); // R6

  property p_power;
    @(posedge core_clk) disable iff (rst) wr_one |=> (right_adc_power_up == $past(reg_wdata[2]));
  endproperty
  a_power: assert property (p_power) else $error("power bit wrong"); // R8

  property p_step;
    @(posedge core_clk) disable iff (rst) wr_one && reg_wdata[1] |=> !input_gain_stage_step_en;
  endproperty
  a_step: assert property (p_step) else $error("stepping not disabled"); // R9

  property p_bias;
    @(posedge core_clk) disable iff (rst) wr_two |=> (unselected_bias_en == $past(reg_wdata[2]));
  endproperty
  a_bias: assert property (p_bias) else $error("bias bit wrong"); // R10

  property p_diff;
    @(posedge core_clk) disable iff (rst)
      wr_one ##1 !wr_one |-> (right_line_input_one_diff == $past(reg_wdata[7]));
  endproperty
  a_diff: assert property (p_diff) else $error("diff select wrong"); // R1

  property p_diff_two;
    @(posedge core_clk) disable iff (rst) wr_two |=> (right_line_input_two_diff == $past(reg_wdata[7]));
  endproperty
  a_diff_two: assert property (p_diff_two) else $error("input two diff wrong"); // R2

  property p_connect_two;
    @(posedge core_clk) disable iff (rst)
      wr_two && (reg_wdata[6:3] <= LEVEL_MAX_CODE) |=> right_line_input_two_connect;
  endproperty
  a_connect_two: assert property (p_connect_two) else $error("input two not connected"); // R5

  property p_open_one;
    @(posedge core_clk) disable iff (rst)
      wr_one && (reg_wdata[6:3] == LEVEL_OPEN_CODE) |=> !right_line_input_one_connect;
  endproperty
  a_open_one: assert property (p_open_one) else $error("input one not disconnected"); // R6

  property p_open_atten_two;
    @(posedge core_clk) disable iff (rst)
      wr_two && (reg_wdata[6:3] == LEVEL_OPEN_CODE) |=> (right_line_input_two_atten == 4'h0);
  endproperty
  a_open_atten_two: assert property (p_open_atten_two) else $error("open input two attenuated"); // R6

  property p_atten_one;
    @(posedge core_clk) disable iff (rst)
      wr_one && (reg_wdata[6:3] <= LEVEL_MAX_CODE) |=> (right_line_input_one_atten == $past(reg_wdata[6:3]));
  endproperty
  a_atten_one: assert property (p_atten_one) else $error("input one level wrong"); // R4

  property p_atten_two;
    @(posedge core_clk) disable iff (rst)
      wr_two && (reg_wdata[6:3] <= LEVEL_MAX_CODE) |=> (right_line_input_two_atten == $past(reg_wdata[6:3]));
  endproperty
  a_atten_two: assert property (p_atten_two) else $error("input two level wrong"); // R4

  property p_step_on;
    @(posedge core_clk) disable iff (rst)
      wr_one && !reg_wdata[1] |=> input_gain_stage_step_en;
  endproperty
  a_step_on: assert property (p_step_on) else $error("stepping not enabled"); // R9

  property p_step_two;
    @(posedge core_clk) disable iff (rst)
      wr_one |=> (input_gain_stage_step_two_fs == ($past(reg_wdata[1:0]) == STEP_TWO_FS));
  endproperty
  a_step_two: assert property (p_step_two) else $error("stepping rate wrong"); // R9

  // ----------------------------------------
  // hold, unmapped and reset checks
  // ----------------------------------------

  property p_one_hold;
    @(posedge core_clk) disable iff (rst)
      !wr_one |=> $stable(line_one_reg);
  endproperty
  a_one_hold: assert property (p_one_hold) else $error("line one moved without write"); // R12

  property p_two_hold;
    @(posedge core_clk) disable iff (rst)
      !wr_two |=> $stable(line_two_reg);
  endproperty
  a_two_hold: assert property (p_two_hold) else $error("line two moved without write"); // R12

  property p_unmapped_zero;
    @(posedge core_clk) disable iff (rst)
      !sel_one && !sel_two |-> (reg_rdata == 8'h00);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // R12

  property p_reset_one;
    @(posedge core_clk)
      rst |=> (line_one_reg == LINE_ONE_RESET);
  endproperty
  a_reset_one: assert property (p_reset_one) else $error("line one reset value wrong"); // R6 R8

  property p_reset_two;
    @(posedge core_clk)
      rst |=> (line_two_view == LINE_TWO_RESET);
  endproperty
  a_reset_two: assert property (p_reset_two) else $error("line two reset value wrong"); // R6 R10
endmodule : rar_route_regs
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the right routing register pair
// assumes rar_pkg, rar_route_regs and rar_host_model are compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] reg_addr;
  logic reg_wr, d1, d2, c1, c2, pwr, bias, sen, s2, con;
  logic [7:0] reg_wdata, reg_rdata, v1, v2, got, want;
  logic [3:0] a1, a2, code;
  int err_total = 0;
  int check_count = 0;
  always #25 core_clk = ~core_clk;
  rar_host_model rar_host_model_inst (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata));
  rar_route_regs rar_route_regs_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .right_line_input_one_diff(d1),
    .right_line_input_two_diff(d2), .right_line_input_one_connect(c1), .right_line_input_two_connect(c2),
    .right_line_input_one_atten(a1), .right_line_input_two_atten(a2), .right_adc_power_up(pwr),
    .unselected_bias_en(bias), .input_gain_stage_step_en(sen), .input_gain_stage_step_two_fs(s2));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic check_reset;
    rar_host_model_inst.rd(7'h16, got);
    chk({8'h00, got}, 16'h0078);
    rar_host_model_inst.rd(7'h17, got);
    chk({8'h00, got}, 16'h0078);
    chk({d1, d2, c1, c2, pwr, bias, sen, s2, a1, a2}, 16'h0200);
  endtask : check_reset
  initial begin
    #50000;
    err_total++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    check_reset();
    $display("reset test done");
    // level codes 0..8 and 1111 only; 9..14 never sent
    for (int k = 0; k < 10; k++) begin
      code = (k == 9) ? 4'hF : 4'(k);
      con = (k != 9);
      v1 = {k[0], code, k[0], k[1:0]};
      v2 = {~k[0], code, k[1], 2'h0};
      rar_host_model_inst.wr(7'h16, v1);
      rar_host_model_inst.wr(7'h17, {v2[7:2], 2'h3});
      want = {v1[7], v2[7], con, con, v1[2], v2[2], ~v1[1], v1[1:0] == 2'h1};
      #1 chk({8'h00, d1, d2, c1, c2, pwr, bias, sen, s2}, {8'h00, want});
      chk({a1, a2}, con ? {code, code} : 16'h0000);
      rar_host_model_inst.rd(7'h16, got);
      chk({8'h00, got}, {8'h00, v1});
      rar_host_model_inst.rd(7'h17, got);
      chk({8'h00, got}, {8'h00, v2});
    end
    $display("level and mode test done");
    rar_host_model_inst.wr(7'h15, 8'hFF);
    rar_host_model_inst.rd(7'h15, got);
    chk({8'h00, got}, 16'h0000);
    rar_host_model_inst.rd(7'h16, got);
    chk({8'h00, got}, {8'h00, v1});
    $display("unmapped test done");
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    check_reset();
    $display("second reset test done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
